// *** verilog/sarseq_top.sv ***
// strobe-driven control sequencer of a parallel-output SAR converter
`timescale 1ns/1ns
`default_nettype none
// How it works
// - first strobe fall with select low powers up and starts acquisition.
// - second strobe fall samples select; high turns reference off afterward.
// - second strobe fall starts conversion of the held input.
// - third strobe fall with select high puts the result on the bus.
// - done flag drops low when conversion completes.
// - reset input high returns everything to reset state.
// - byte variant shows upper byte when byte-select 1, lower when 0.
// - result leaves on three-state outputs, bit 15 most significant.
module sarseq_top
  import sarseq_pkg::*;
(
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire sarseq_host_t host_in,
  input wire logic cmp_in,
  output logic [RES_W-1:0] data_out,
  output logic [RES_W-1:0] data_oe_out,
  output logic [BYTE_W-1:0] byte_data_out,
  output logic [BYTE_W-1:0] byte_data_oe_out,
  output logic eoc_n_out,
  output logic [RES_W-1:0] dac_trial_out,
  output sarseq_ana_t ana_out
);
  sarseq_state_t st_q, st_d;
  logic strobe_q, strobe_d;
  logic ref_off_q, ref_off_d;
  logic ref_on_q, ref_on_d;
  logic eoc_n_q, eoc_n_d;
  logic drive_q, drive_d;
  logic [RES_W-1:0] word_q, word_d;
  logic [BYTE_W-1:0] byte_q, byte_d;
  logic fall, sar_start, sar_done;
  logic [RES_W-1:0] sar_result;

  // ---------------------------------------------------------------
  // converter core
  // ---------------------------------------------------------------
  sarseq_sar u_sar (
    .mclk_in(mclk_in),
    .rst_in(rst_in),
    .start_in(sar_start),
    .cmp_in(cmp_in),
    .trial_out(dac_trial_out),
    .result_out(sar_result),
    .done_out(sar_done)
  );

  // ---------------------------------------------------------------
  // strobe sequence
  // ---------------------------------------------------------------
  assign fall = strobe_q & ~host_in.strobe_n;

  always_comb
  begin
    st_d = st_q;
    strobe_d = host_in.strobe_n;
    ref_off_d = ref_off_q;
    ref_on_d = ref_on_q;
    eoc_n_d = eoc_n_q;
    drive_d = drive_q;
    word_d = word_q;
    sar_start = 1'b0;
    // strobe rising ends the bus cycle: float, and release the flag only when in the read state
    if (!strobe_q && host_in.strobe_n)
    begin
      drive_d = 1'b0;
      if (st_q == SQ_READ)
        eoc_n_d = 1'b1;
    end
    case (st_q)
      SQ_OFF:
      begin
        if (fall && !host_in.read_sel)
        begin
          st_d = SQ_ACQ;
          ref_on_d = 1'b1;
        end
      end
      SQ_ACQ:
      begin
        if (fall)
        begin
          ref_off_d = host_in.read_sel;
          sar_start = 1'b1;
          st_d = SQ_CONV;
        end
      end
      SQ_CONV:
      begin
        if (sar_done)
        begin
          word_d = sar_result;
          eoc_n_d = 1'b0;
          st_d = SQ_DONE;
          // reference drops after conversion when asked
          if (ref_off_q)
            ref_on_d = 1'b0;
        end
      end
      SQ_DONE:
      begin
        // relies on host waiting for the flag before this edge
        if (fall && host_in.read_sel)
        begin
          drive_d = 1'b1;
          st_d = SQ_READ;
        end
      end
      SQ_READ:
      begin
        // a new acquisition may begin once the read is over
        if (fall && !host_in.read_sel)
        begin
          st_d = SQ_ACQ;
          ref_on_d = 1'b1;
          eoc_n_d = 1'b1;
          drive_d = 1'b0;
        end
      end
      default:
      begin
        st_d = SQ_OFF;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // byte mux, registered so data follows byte-select one clock later
  // ---------------------------------------------------------------
  always_comb
  begin
    if (host_in.upper_byte_select)
      byte_d = word_d[MSB_POS -: BYTE_W];
    else
      byte_d = word_d[BYTE_W-1:0];
  end

  always_ff @(posedge mclk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      st_q <= SQ_OFF;
      strobe_q <= 1'b1;
      ref_off_q <= 1'b0;
      ref_on_q <= 1'b0;
      eoc_n_q <= 1'b1;
      drive_q <= 1'b0;
      word_q <= RES_RST;
      byte_q <= '0;
    end
    else
    begin
      st_q <= st_d;
      strobe_q <= strobe_d;
      ref_off_q <= ref_off_d;
      ref_on_q <= ref_on_d;
      eoc_n_q <= eoc_n_d;
      drive_q <= drive_d;
      word_q <= word_d;
      byte_q <= byte_d;
    end
  end

  // ---------------------------------------------------------------
  // pins
  // ---------------------------------------------------------------
  assign data_out = word_q;
  assign data_oe_out = {RES_W{drive_q}};
  assign byte_data_out = byte_q;
  assign byte_data_oe_out = {BYTE_W{drive_q}};
  assign eoc_n_out = eoc_n_q;
  // one driver for the whole status struct
  assign ana_out = {ref_on_q, st_q == SQ_ACQ};
endmodule
`default_nettype wire

// *** verilog/sarseq_pkg.sv ***
// shared constants, states and carrier types for the strobe sequencer
package sarseq_pkg;
  localparam int unsigned CLK_MHZ = 25;
  localparam int unsigned CONV_TIME_NS = 4700;
  // longest time, rounded down
  localparam int unsigned CONV_CYC = (CONV_TIME_NS * CLK_MHZ) / 1000;
  localparam int unsigned ACQ_TIME_NS = 1100;
  // least time, rounded up
  localparam int unsigned ACQ_CYC = (ACQ_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned CNT_W = 8;
  localparam int unsigned RES_W = 16;
  localparam int unsigned BYTE_W = 8;
  localparam int unsigned MSB_POS = 15;
  localparam logic [RES_W-1:0] RES_RST = 16'h0000;
  localparam logic [RES_W-1:0] SAR_START = 16'h8000;

  typedef enum logic [4:0] {
    SQ_OFF  = 5'h01,
    SQ_ACQ  = 5'h02,
    SQ_CONV = 5'h04,
    SQ_DONE = 5'h08,
    SQ_READ = 5'h10
  } sarseq_state_t;

  // host-side control pins, taken together
  typedef struct packed {
    logic strobe_n;
    logic read_sel;
    logic upper_byte_select;
  } sarseq_host_t;

  // analog side status driven by the digital logic
  typedef struct packed {
    logic ref_powered;
    logic tracking;
  } sarseq_ana_t;
endpackage

// *** verilog/sarseq_sar.sv ***
// successive-approximation register stepping one bit per clock
`timescale 1ns/1ns
`default_nettype none
module sarseq_sar
  import sarseq_pkg::*;
(
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic start_in,
  input wire logic cmp_in,
  output logic [RES_W-1:0] trial_out,
  output logic [RES_W-1:0] result_out,
  output logic done_out
);
  logic [RES_W-1:0] trial_q, trial_d, bit_q, bit_d, res_q, res_d;
  logic done_q, done_d;

  always_comb
  begin
    trial_d = trial_q;
    bit_d = bit_q;
    res_d = res_q;
    done_d = 1'b0;
    if (start_in)
    begin
      trial_d = SAR_START;
      bit_d = SAR_START;
    end
    else if (bit_q != RES_RST)
    begin
      // keep the trial bit when the comparator says input is above
      if (!cmp_in)
        trial_d = trial_q & ~bit_q;
      bit_d = bit_q >> 1;
      if (bit_q[0])
      begin
        res_d = cmp_in ? trial_q : (trial_q & ~bit_q);
        done_d = 1'b1;
      end
      else
        trial_d = trial_d | (bit_q >> 1);
    end
  end

  always_ff @(posedge mclk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      trial_q <= RES_RST;
      bit_q <= RES_RST;
      res_q <= RES_RST;
      done_q <= 1'b0;
    end
    else
    begin
      trial_q <= trial_d;
      bit_q <= bit_d;
      res_q <= res_d;
      done_q <= done_d;
    end
  end

  assign trial_out = trial_q;
  assign result_out = res_q;
  assign done_out = done_q;
endmodule
`default_nettype wire

// *** tb/sarseq_properties.sv ***
// checker of the strobe sequencer ports
`timescale 1ns/1ns
`default_nettype none
module sarseq_properties
  import sarseq_pkg::*;
(
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire sarseq_host_t host_in,
  input wire logic [RES_W-1:0] data_out,
  input wire logic [RES_W-1:0] data_oe_out,
  input wire logic [BYTE_W-1:0] byte_data_out,
  input wire logic [BYTE_W-1:0] byte_data_oe_out,
  input wire logic eoc_n_out,
  input wire sarseq_ana_t ana_out
);
  default clocking @(posedge mclk_in);
  endclocking
  default disable iff (rst_in);
  chk_oe_pair: assert property (byte_data_oe_out == data_oe_out[7:0])
    else $error("byte enable differs from word enable");
  chk_byte_mux: assert property (data_oe_out[0] && $past(data_oe_out[0]) |->
    byte_data_out == ($past(host_in.upper_byte_select) ? data_out[15:8]
    : data_out[7:0])) else $error("wrong byte on bus");
  chk_oe_drop: assert property (data_oe_out[0] && host_in.strobe_n |=>
    !data_oe_out[0]) else $error("bus kept after strobe rise");
  chk_load_gate: assert property ($rose(data_oe_out[0]) |-> !eoc_n_out &&
    !$past(host_in.strobe_n) && $past(host_in.read_sel))
    else $error("bad load");
  chk_acq_entry: assert property ($rose(ana_out.tracking) |->
    ana_out.ref_powered && !$past(host_in.strobe_n) &&
    !$past(host_in.read_sel)) else $error("bad acquisition start");
  chk_conv_start: assert property (ana_out.tracking &&
    $fell(host_in.strobe_n) |=> !ana_out.tracking) else $error("no start");
  chk_eoc_time: assert property ($fell(ana_out.tracking) |->
    eoc_n_out[*8] ##[1:14] !eoc_n_out) else $error("done flag timing");
  chk_rst_state: assert property (disable iff (1'b0) rst_in |->
    eoc_n_out && data_oe_out == 16'h0000) else $error("reset state");
endmodule
bind sarseq_top sarseq_properties chk (.mclk_in, .rst_in, .host_in,
  .data_out, .data_oe_out, .byte_data_out, .byte_data_oe_out, .eoc_n_out,
  .ana_out);
`default_nettype wire

// *** tb/sarseq_host_model.sv ***
// host bus model driving strobe and read/convert select
`timescale 1ns/1ns
`default_nettype none
module sarseq_host_model
(
  input wire logic mclk_in,
  output logic strobe_n_out,
  output logic read_sel_out
);
  initial
  begin
    strobe_n_out = 1'b1;
    read_sel_out = 1'b0;
  end
  // low for n rising edges; select no longer held after the rise
  task automatic strobe(input logic sel, input int n);
    @(negedge mclk_in);
    strobe_n_out = 1'b0;
    read_sel_out = sel;
    repeat (n) @(negedge mclk_in);
    strobe_n_out = 1'b1;
    read_sel_out = ~sel;
  endtask
endmodule
`default_nettype wire

// *** tb/tb.sv ***
// self-checking bench for the strobe sequencer
`timescale 1ns/1ns
`default_nettype none
module tb
  import sarseq_pkg::*;
;
  logic clk, rst, ubs, sn, rs, eoc_n, oe_p, ub_p;
  logic [RES_W-1:0] ain, dout, doe, trial, w;
  logic [BYTE_W-1:0] bout;
  sarseq_ana_t ana;
  logic [RES_W-1:0] exp_q[$];
  int n_mismatch = 0;
  int check_count = 0;
  int seed = 32'h605AD068;
  sarseq_host_model host (.mclk_in(clk), .strobe_n_out(sn),
    .read_sel_out(rs));
  // analog input sits half a step above ain, so the code settles on ain
  sarseq_top uut (.mclk_in(clk), .rst_in(rst), .host_in({sn, rs, ubs}),
    .cmp_in(ain >= trial), .data_out(dout), .data_oe_out(doe),
    .byte_data_out(bout), .byte_data_oe_out(), .eoc_n_out(eoc_n),
    .dac_trial_out(trial), .ana_out(ana));
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic cmp(input logic [RES_W-1:0] e, input logic [RES_W-1:0] g);
    check_count++;
    if (e !== g)
    begin
      n_mismatch++;
      $display("[ERR] t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  task finish_test;
    // a result that never reached the bus is a failure too
    if (exp_q.size() != 0)
      n_mismatch++;
    $display("checks=%0d mismatches=%0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task start(input logic [RES_W-1:0] a, input logic pd);
    ain = a;
    host.strobe(1'b0, 1);
    repeat (3) @(negedge clk);
    host.strobe(pd, 1);
  endtask
  task conv(input logic [RES_W-1:0] a, input logic pd);
    int k;
    start(a, pd);
    host.strobe(1'b1, 1);
    for (k = 0; k < 40 && eoc_n !== 1'b0; k++) @(negedge clk);
    if (k == 40)
    begin
      n_mismatch++;
      finish_test;
    end
    exp_q.push_back(a);
    fork
      host.strobe(1'b1, 4);
      repeat (5) @(negedge clk) ubs = 1'($random(seed));
    join
    repeat (2) @(negedge clk);
    cmp(16'h0001, {15'h0000, eoc_n});
    cmp({15'h0000, !pd}, {15'h0000, ana.ref_powered});
    cmp(16'h0000, doe);
  endtask
  // ----
  // result monitor
  // ----
  // byte-select as the design registered it at the last rising edge
  always @(posedge clk)
    ub_p <= ubs;
  // look at settled outputs, away from the launching edge
  always @(negedge clk)
  begin
    if (doe[0] && !oe_p)
    begin
      w = exp_q.size() ? exp_q.pop_front() : 16'hXXXX;
      cmp(w, dout);
    end
    else if (doe[0])
      cmp({8'h00, ub_p ? w[15:8] : w[7:0]}, {8'h00, bout});
    oe_p = doe[0];
  end
  initial
  begin
    rst = 1'b1;
    ubs = 1'b0;
    ain = 16'h0000;
    oe_p = 1'b0;
    repeat (20) @(posedge clk);
    @(negedge clk) rst = 1'b0;
    repeat (2) @(negedge clk);
    host.strobe(1'b1, 1);
    repeat (2) @(negedge clk);
    cmp(16'h0000, {15'h0000, ana.tracking});
    for (int i = 0; i < 6; i++)
    begin
      conv(i == 0 ? 16'h0000 : i == 1 ? 16'hFFFF : 16'($random(seed)), i[0]);
      $display("test %0d done", i);
    end
    start(16'h5A5A, 1'b0);
    repeat (5) @(negedge clk);
    rst = 1'b1;
    @(negedge clk);
    cmp(16'h0001, {15'h0000, eoc_n});
    rst = 1'b0;
    repeat (2) @(negedge clk);
    conv(16'h1234, 1'b0);
    $display("test reset done");
    finish_test;
  end
endmodule
`default_nettype wire
